// >>> inc/pie_pkg.sv
// shared constants for the peripheral interrupt enable block
package pie_pkg;

   // bus, register and status widths
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADR_W = 8;
   localparam int unsigned REG_W = 8;
   localparam int unsigned ST_W = 4;

   // register byte offsets
   localparam logic [7:0] OFS_ENABLE_ONE = 8'h00;
   localparam logic [7:0] OFS_ENABLE_TWO = 8'h04;
   localparam logic [7:0] OFS_CORE_CTRL = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;

   // implemented storage per register
   localparam logic [7:0] ENABLE_ONE_IMPL = 8'hFF;
   localparam logic [7:0] ENABLE_TWO_IMPL = 8'h4E;
   localparam logic [7:0] CORE_CTRL_IMPL = 8'h01;

   // values after reset
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [3:0] STATUS_RESET = 4'h0;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // field positions
   localparam int unsigned CONV_BIT = 6;
   localparam int unsigned RX_BIT = 5;
   localparam int unsigned CONV2_BIT = 6;
   localparam int unsigned MASTER_BIT = 0;

   // status and mask field positions
   localparam int unsigned ST_ANY = 0;
   localparam int unsigned ST_CONV = 1;
   localparam int unsigned ST_CONV2 = 2;
   localparam int unsigned ST_RX = 3;

endpackage

// >>> logic/enable_reg.sv
// one 8-bit enable register with implemented-bit mask and request gating
`timescale 1ns/1ps
module enable_reg
   import pie_pkg::*;
#(
   parameter logic [7:0] IMPL_MASK = 8'hFF,
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // software write
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   // request gating
   input wire logic [7:0] req_i,
   output logic [7:0] en_o,
   output logic [7:0] gated_o
);

   logic [7:0] en_q;
   logic [7:0] en_d;

   // unimplemented positions never store a one
   assign en_d = wr_i ? (wdata_i & IMPL_MASK) : en_q;

   // enable storage, loaded with RESET_VAL under the implemented mask by any reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q <= RESET_VAL & IMPL_MASK;
      end else begin
         en_q <= en_d;
      end
   end

   // a request passes only where its enable is one
   assign gated_o = req_i & en_q;
   assign en_o = en_q;

endmodule

// >>> logic/periph_irq_enable.sv
// peripheral interrupt enable registers with wishbone access and core request
//
// Function
// - Bit six of the first enable register passes the converter request when one and blocks it when zero.
// - Bit six of the second enable register passes the second converter request when one and blocks it when zero.
// - Bit five of the first enable register passes the serial receive request when one and blocks it when zero.
// - Bits seven, five, four and zero of the second enable register store nothing, read as zero and ignore writes.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module periph_irq_enable
   import pie_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [DATA_W-1:0] dat_i,
   output logic [DATA_W-1:0] dat_o,
   output logic ack_o,
   // peripheral requests, same clock domain
   input wire logic [REG_W-1:0] req_one_i,
   input wire logic [REG_W-1:0] req_two_i,
   // gated requests and core request
   output logic [REG_W-1:0] gated_one_o,
   output logic [REG_W-1:0] gated_two_o,
   output logic periph_irq_o,
   // masked status interrupt
   output logic irq_o
);

   // bus and register state
   logic ack_q;
   logic [DATA_W-1:0] dat_q;
   logic [REG_W-1:0] core_ctrl_q;
   logic [ST_W-1:0] mask_q;
   logic [REG_W-1:0] gated_one_q;
   logic [REG_W-1:0] gated_two_q;
   logic periph_irq_q;
   logic irq_q;

   // combinational nets
   logic req_hit;
   logic req_new;
   logic wr_take;
   logic hit_one;
   logic hit_two;
   logic hit_core;
   logic hit_status;
   logic hit_mask;
   logic [REG_W-1:0] en_one;
   logic [REG_W-1:0] en_two;
   logic [REG_W-1:0] gated_one;
   logic [REG_W-1:0] gated_two;
   logic [DATA_W-1:0] rd_word;
   logic master_en;
   logic periph_irq_d;
   logic [ST_W-1:0] ev_set;
   logic [ST_W-1:0] ev_clr;
   logic [ST_W-1:0] status;

   // address decode on word boundaries
   assign hit_one = (adr_i[7:2] == OFS_ENABLE_ONE[7:2]);
   assign hit_two = (adr_i[7:2] == OFS_ENABLE_TWO[7:2]);
   assign hit_core = (adr_i[7:2] == OFS_CORE_CTRL[7:2]);
   assign hit_status = (adr_i[7:2] == OFS_STATUS[7:2]);
   assign hit_mask = (adr_i[7:2] == OFS_MASK[7:2]);

   // a cycle is new until acked; a write lands on the edge that samples ack
   assign req_hit = cyc_i & stb_i;
   assign req_new = req_hit & ~ack_q;
   assign wr_take = req_hit & we_i & ack_q & sel_i[0];

   // first enable register, all eight bits stored
   enable_reg #(
      .IMPL_MASK(ENABLE_ONE_IMPL),
      .RESET_VAL(ENABLE_RESET)
   ) u_enable_one (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_take & hit_one),
      .wdata_i(dat_i[7:0]),
      .req_i(req_one_i),
      .en_o(en_one),
      .gated_o(gated_one)
   );

   // second enable register, unimplemented bits masked off
   enable_reg #(
      .IMPL_MASK(ENABLE_TWO_IMPL),
      .RESET_VAL(ENABLE_RESET)
   ) u_enable_two (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_take & hit_two),
      .wdata_i(dat_i[7:0]),
      .req_i(req_two_i),
      .en_o(en_two),
      .gated_o(gated_two)
   );

   // core control holds the peripheral master enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_ctrl_q <= ENABLE_RESET;
      end else if (wr_take & hit_core) begin
         core_ctrl_q <= dat_i[7:0] & CORE_CTRL_IMPL;
      end
   end

   assign master_en = core_ctrl_q[MASTER_BIT];

   // the core sees a request only behind the master enable
   assign periph_irq_d = master_en & (|gated_one | |gated_two);

   // registered gated requests toward the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gated_one_q <= ENABLE_RESET;
         gated_two_q <= ENABLE_RESET;
         periph_irq_q <= 1'b0;
      end else begin
         gated_one_q <= gated_one;
         gated_two_q <= gated_two;
         periph_irq_q <= periph_irq_d;
      end
   end

   // events are rising edges of the gated lines
   assign ev_set[ST_ANY] = periph_irq_d & ~periph_irq_q;
   assign ev_set[ST_CONV] = gated_one[CONV_BIT] & ~gated_one_q[CONV_BIT];
   assign ev_set[ST_CONV2] = gated_two[CONV2_BIT] & ~gated_two_q[CONV2_BIT];
   assign ev_set[ST_RX] = gated_one[RX_BIT] & ~gated_one_q[RX_BIT];
   assign ev_clr = (wr_take & hit_status) ? dat_i[ST_W-1:0] : '0;

   // sticky status, write one to clear
   sticky_status #(
      .W(ST_W)
   ) u_status (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(ev_set),
      .clr_i(ev_clr),
      .flag_o(status)
   );

   // interrupt mask and level output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= STATUS_RESET;
         irq_q <= 1'b0;
      end else begin
         if (wr_take & hit_mask) begin
            mask_q <= dat_i[ST_W-1:0];
         end
         irq_q <= |(status & mask_q);
      end
   end

   // read selection; unmapped words and reserved bits read zero
   assign rd_word = hit_one ? {24'h00_0000, en_one} :
      hit_two ? {24'h00_0000, en_two} :
      hit_core ? {24'h00_0000, core_ctrl_q} :
      hit_status ? {28'h000_0000, status} :
      hit_mask ? {28'h000_0000, mask_q} :
      READ_ZERO;

   // one-cycle ack, data captured with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= READ_ZERO;
      end else begin
         ack_q <= req_new;
         if (req_new) begin
            dat_q <= rd_word;
         end
      end
   end

   // outputs straight from flip-flops
   assign dat_o = dat_q;
   assign ack_o = ack_q;
   assign gated_one_o = gated_one_q;
   assign gated_two_o = gated_two_q;
   assign periph_irq_o = periph_irq_q;
   assign irq_o = irq_q;

   // checks on the enables, the master gate, the status flags, the interrupt and the bus
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_conv_pass: assert property (
      gated_one_o[CONV_BIT] == $past(req_one_i[CONV_BIT] && en_one[CONV_BIT]))
      else $error("converter request not gated by its enable");

   chk_conv2_pass: assert property (
      gated_two_o[CONV2_BIT] == $past(req_two_i[CONV2_BIT] && en_two[CONV2_BIT]))
      else $error("second converter request not gated by its enable");

   chk_rx_pass: assert property (
      (!en_one[RX_BIT] ##1 !en_one[RX_BIT]) |-> !gated_one_o[RX_BIT])
      else $error("serial receive request passed while disabled");

   chk_rx_enabled: assert property (
      (req_one_i[RX_BIT] && en_one[RX_BIT]) |=> gated_one_o[RX_BIT])
      else $error("serial receive request blocked while enabled");

   chk_unimpl_zero: assert property (
      (req_new && hit_two && !we_i) |=> ack_o && (dat_o[7:0] & ~ENABLE_TWO_IMPL) == 8'h00
      && dat_o[31:8] == 24'h00_0000)
      else $error("unimplemented bits of second enable read nonzero");

   chk_write_lands: assert property (
      (wr_take && hit_one) |=> en_one == $past(dat_i[7:0]))
      else $error("write to first enable did not land");

   chk_write_two: assert property (
      (wr_take && hit_two) |=> en_two == ($past(dat_i[7:0]) & ENABLE_TWO_IMPL))
      else $error("write to second enable did not land");

   chk_reset_clear: assert property (@(posedge clk_i)
      $past(rst_i) |-> (en_one == 8'h00 && en_two == 8'h00))
      else $error("enables not cleared by reset");

   chk_master_gate: assert property (
      (!master_en ##1 !master_en) |-> !periph_irq_o)
      else $error("core request without master enable");

   chk_master_pass: assert property (
      (master_en && (|gated_one || |gated_two)) |=> periph_irq_o)
      else $error("enabled request did not reach the core");

   chk_status_set: assert property (
      ev_set[ST_CONV2] |=> status[ST_CONV2])
      else $error("second converter event lost against a clear");

   chk_status_clear: assert property (
      (ev_clr[ST_CONV] && !ev_set[ST_CONV]) |=> !status[ST_CONV])
      else $error("write one did not clear the converter flag");

   chk_ack_pulse: assert property (
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   chk_irq_level: assert property (
      (|(status & mask_q)) |=> irq_o)
      else $error("unmasked status did not raise interrupt");

   // main scenarios
   cov_conv_core: cover property (
      master_en && gated_one[CONV_BIT] ##1 periph_irq_o);
   cov_rx_blocked: cover property (
      req_one_i[RX_BIT] && !en_one[RX_BIT] ##1 !gated_one_o[RX_BIT]);
   cov_clear_race: cover property (
      ev_set[ST_CONV2] && ev_clr[ST_CONV2]);
   cov_irq_out: cover property (
      !irq_o ##1 irq_o);

endmodule

// >>> logic/sticky_status.sv
// sticky event flags, write one to clear, a new event beats the clear
`timescale 1ns/1ps
module sticky_status
   import pie_pkg::*;
#(
   parameter int unsigned W = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // events and clears
   input wire logic [W-1:0] set_i,
   input wire logic [W-1:0] clr_i,
   output logic [W-1:0] flag_o
);

   logic [W-1:0] flag_q;
   logic [W-1:0] flag_d;

   // set is applied after clear so a same-cycle event survives
   assign flag_d = (flag_q & ~clr_i) | set_i;

   // flag storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;

endmodule

// >>> sim/periph_sources.sv
// model of the peripheral request sources that feed the enable block
`timescale 1ns/1ps
module periph_sources (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // levels requested by the bench
   input wire logic [7:0] one_i,
   input wire logic [7:0] two_i,
   // request lines toward the block
   output logic [7:0] req_one_o,
   output logic [7:0] req_two_o
);
   // each source holds its request as a level, launched just after the edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_one_o <= 8'h00;
         req_two_o <= 8'h00;
      end else begin
         req_one_o <= one_i;
         req_two_o <= two_i;
      end
   end
endmodule

// >>> sim/testbench.sv
// self-checking bench for the peripheral interrupt enable block
`timescale 1ns/1ps
module testbench;
   import pie_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [ADR_W-1:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [DATA_W-1:0] wdat = 32'h0000_0000;
   logic [DATA_W-1:0] rdat;
   logic ack;
   logic [7:0] src_one = 8'h00;
   logic [7:0] src_two = 8'h00;
   logic [7:0] req_one;
   logic [7:0] req_two;
   logic [7:0] gated_one;
   logic [7:0] gated_two;
   logic periph_irq;
   logic irq;
   logic [31:0] q;
   int fails = 0;
   int checked = 0;

   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end

   periph_sources src (.clk_i(clk), .rst_i(rst), .one_i(src_one), .two_i(src_two),
      .req_one_o(req_one), .req_two_o(req_two));

   periph_irq_enable dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .req_one_i(req_one), .req_two_i(req_two), .gated_one_o(gated_one),
      .gated_two_o(gated_two), .periph_irq_o(periph_irq), .irq_o(irq));

   task automatic finish_test();
      if (fails == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one comparison, reported at once on a mismatch
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // classic wishbone cycle: request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] s, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         fails++;
         finish_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 4'h1, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 8'h00, 4'h1, q);
      chk(q, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test();
   end

   initial begin
      tick(6);
      rst <= 1'b0;
      rd(OFS_ENABLE_ONE, 32'h0000_0000);
      rd(OFS_ENABLE_TWO, 32'h0000_0000);
      rd(OFS_CORE_CTRL, 32'h0000_0000);
      wr(OFS_ENABLE_TWO, 8'hFF);
      rd(OFS_ENABLE_TWO, 32'h0000_004E);
      wr(OFS_ENABLE_ONE, 8'hFF);
      rd(OFS_ENABLE_ONE, 32'h0000_00FF);
      // enable only the named sources, then raise every request line
      wr(OFS_ENABLE_ONE, 8'h60);
      wr(OFS_ENABLE_TWO, 8'h40);
      wr(OFS_CORE_CTRL, 8'h01);
      src_one <= 8'hFF;
      src_two <= 8'hFF;
      tick(3);
      chk({24'h00_0000, gated_one}, 32'h0000_0060);
      chk({24'h00_0000, gated_two}, 32'h0000_0040);
      chk({31'h0, periph_irq}, 32'h0000_0001);
      // sticky status, mask and write-one-to-clear
      rd(OFS_STATUS, 32'h0000_000F);
      wr(OFS_MASK, 8'h02);
      tick(2);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(OFS_STATUS, 8'h02);
      tick(2);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(OFS_STATUS, 32'h0000_000D);
      // each converter enable blocks its own request when cleared
      wr(OFS_ENABLE_ONE, 8'h20);
      tick(2);
      chk({24'h00_0000, gated_one}, 32'h0000_0020);
      wr(OFS_ENABLE_TWO, 8'h00);
      tick(2);
      chk({24'h00_0000, gated_two}, 32'h0000_0000);
      // a new event beats a write-one clear that lands in the same cycle
      src_two <= 8'h00;
      wr(OFS_ENABLE_TWO, 8'h40);
      wr(OFS_STATUS, 8'h04);
      rd(OFS_STATUS, 32'h0000_0009);
      fork
         wr(OFS_STATUS, 8'h04);
         begin
            @(posedge clk);
            src_two <= 8'h40;
         end
      join
      rd(OFS_STATUS, 32'h0000_000D);
      wr(OFS_ENABLE_ONE, 8'h40);
      tick(2);
      chk({24'h00_0000, gated_one}, 32'h0000_0040);
      wr(OFS_CORE_CTRL, 8'h00);
      tick(2);
      chk({31'h0, periph_irq}, 32'h0000_0000);
      // unmapped place and a write with the low byte lane off
      wr(8'h20, 8'hFF);
      rd(8'h20, 32'h0000_0000);
      wb(1'b1, OFS_ENABLE_ONE, 8'hFF, 4'h0, q);
      rd(OFS_ENABLE_ONE, 32'h0000_0040);
      // reset in mid-run clears every enable
      wr(OFS_ENABLE_TWO, 8'h4E);
      @(posedge clk);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      rd(OFS_ENABLE_ONE, 32'h0000_0000);
      rd(OFS_ENABLE_TWO, 32'h0000_0000);
      chk({24'h00_0000, gated_one}, 32'h0000_0000);
      finish_test();
   end
endmodule
